//--- src/bic_top.v
// bridge interrupt line, pin select and bridge control bank with its effects
`timescale 1ns/1ps
`include "bic_regs.vh"
module bic_top (
    // clock and reset
    input  wire                   mclk,
    input  wire                   rst_n,
    // register port
    input  wire [`BIC_ADDR_W-1:0] reg_addr,
    input  wire [15:0]            reg_wdata,
    input  wire                   reg_wr,
    input  wire                   reg_rd,
    output reg  [15:0]            reg_rdata,
    // error reporting enables from command and device control
    input  wire                   cmd_err_en,
    input  wire                   devctl_err_en,
    // secondary side events, one-cycle pulses
    input  wire                   sec_poison,
    input  wire                   sec_err_msg,
    input  wire [1:0]             sec_err_kind,
    // primary error message out
    output reg                    pri_err_valid,
    output reg  [1:0]             pri_err_kind,
    output reg                    parity_err,
    // downstream I/O request classification
    input  wire                   io_req,
    input  wire [15:0]            io_addr,
    input  wire                   io_in_window,
    output reg                    io_fwd_down,
    output reg                    io_fwd_up,
    // secondary reset and legacy interrupt select
    input  wire                   port_is_upstream,
    output reg                    sec_reset,
    output reg                    sec_reset_up,
    output reg  [2:0]             legacy_int_sel,
    // status of control bits
    output reg                    vga_active
);
    reg  [7:0]  int_line_reg;
    reg  [7:0]  int_pin_reg;
    reg  [15:0] ctl_reg;
    wire        poison_report_enable;
    wire        error_forward_enable;
    wire        legacy_io_upstream_enable;
    wire        vga_forward_enable;
    wire        vga_wide_decode;
    wire        secondary_reset_trigger;
    wire        isa_up;
    wire        vga_hit;
    wire        up_strap;

    assign poison_report_enable      = ctl_reg[`BIC_BIT_POISON];
    assign error_forward_enable      = ctl_reg[`BIC_BIT_ERRFWD];
    assign legacy_io_upstream_enable = ctl_reg[`BIC_BIT_ISA];
    assign vga_forward_enable        = ctl_reg[`BIC_BIT_VGA];
    assign vga_wide_decode           = ctl_reg[`BIC_BIT_VGA16];
    assign secondary_reset_trigger   = ctl_reg[`BIC_BIT_SECONDARY_RESET_TRIGGER];

    // port type strap may come from a pin, so synchronise it
    bic_sync2 u_strap (
        .mclk  (mclk),
        .rst_n (rst_n),
        .d_in  (port_is_upstream),
        .q_out (up_strap)
    );

    bic_io_decode u_dec (
        .io_addr      (io_addr),
        .isa_en       (legacy_io_upstream_enable),
        .vga_en       (vga_forward_enable),
        .vga_wide     (vga_wide_decode),
        .isa_upstream (isa_up),
        .vga_hit      (vga_hit)
    );

    // register writes; byte registers sit at 0x03C and 0x03D, each in data bits 7:0
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            int_line_reg <= `BIC_RST_INT_LINE; // RULE1
            int_pin_reg  <= `BIC_RST_INT_PIN; // RULE4
            ctl_reg      <= `BIC_RST_BRIDGE_CTL;
        end else if (reg_wr) begin
            if (reg_addr == `BIC_OFF_INT_LINE) begin
                int_line_reg <= reg_wdata[7:0]; // RULE1
            end
            if (reg_addr == `BIC_OFF_INT_PIN) begin
                // stored as written; values above four are undefined for software
                int_pin_reg <= reg_wdata[7:0]; // RULE3
            end
            if (reg_addr == `BIC_OFF_BRIDGE_CTL) begin
                ctl_reg <= reg_wdata & `BIC_CTL_WMASK; // RULE13
            end
        end
    end

    // read data one cycle after strobe; unmapped reads zero
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `BIC_OFF_INT_LINE:   reg_rdata <= {8'h00, int_line_reg};
                `BIC_OFF_INT_PIN:    reg_rdata <= {8'h00, int_pin_reg};
                `BIC_OFF_BRIDGE_CTL: reg_rdata <= ctl_reg & `BIC_CTL_WMASK; // RULE13
                default:             reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // secondary error handling
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            parity_err    <= 1'b0;
            pri_err_valid <= 1'b0;
            pri_err_kind  <= 2'h0;
        end else begin
            parity_err    <= sec_poison && poison_report_enable; // RULE5
            // forwarding needs both the bridge gate and a reporting enable
            pri_err_valid <= sec_err_msg && error_forward_enable // RULE6
                             && (cmd_err_en || devctl_err_en); // RULE7
            pri_err_kind  <= sec_err_kind;
        end
    end

    // I/O routing, registered so outputs come from flops
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            io_fwd_down <= 1'b0;
            io_fwd_up   <= 1'b0;
            vga_active  <= 1'b0;
        end else begin
            // ISA alias slots go up instead of down, unless a VGA range claims them
            io_fwd_down <= io_req && ((io_in_window && !isa_up) || vga_hit); // RULE8 RULE9
            io_fwd_up   <= io_req && io_in_window && isa_up && !vga_hit; // RULE8
            vga_active  <= vga_forward_enable; // RULE9
        end
    end

    // secondary reset follows the bit level
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sec_reset    <= 1'b0;
            sec_reset_up <= 1'b0;
        end else begin
            sec_reset    <= secondary_reset_trigger && !up_strap; // RULE12 RULE14
            sec_reset_up <= secondary_reset_trigger && up_strap; // RULE12 RULE14
        end
    end

    // legacy interrupt message select; out-of-range treated as none
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            legacy_int_sel <= `BIC_MSG_NONE;
        end else if (int_pin_reg <= `BIC_PIN_MAX) begin
            legacy_int_sel <= int_pin_reg[2:0]; // RULE2
        end else begin
            legacy_int_sel <= `BIC_MSG_NONE;
        end
    end
endmodule // bic_top

//--- src/bic_regs.vh
// register offsets, field positions and reset values of the bridge interrupt/control bank
// Functional notes
// (RULE1) routing line is 8-bit RW, resets zero, stored only, never used by logic.
// (RULE2) pin select 0 means no interrupt; 1..4 select INTA..INTD messages.
// (RULE3) software should program pin select only with values zero through four.
// (RULE4) pin select resets to zero, no legacy interrupt used by default.
// (RULE5) control bit 0 clear ignores secondary poison; set reports it as parity error.
// (RULE6) control bit 1 set forwards secondary error messages to primary; clear blocks.
// (RULE7) forwarded errors reported only if command or device control reporting enabled.
// (RULE8) bit 2 clear forwards whole I/O window down; set sends ISA aliases upstream.
// (RULE9) control bit 3 set forwards VGA addresses primary to secondary; clear blocks.
// (RULE10) VGA width bit 4 matters only while VGA forwarding bit is set.
// (RULE11) width bit clear decodes 10 address bits with aliases; set decodes 16 bits.
// (RULE12) setting control bit 6 starts a secondary bus reset.
// (RULE13) reserved control bits 5 and 15:7 read zero, writes ignored.
// (RULE14) secondary reset stays asserted while bit is set, released when cleared.
`ifndef BIC_REGS_VH
`define BIC_REGS_VH
`define BIC_ADDR_W          12
`define BIC_OFF_INT_LINE    12'h03C
`define BIC_OFF_INT_PIN     12'h03D
`define BIC_OFF_BRIDGE_CTL  12'h03E
`define BIC_RST_INT_LINE    8'h00
`define BIC_RST_INT_PIN     8'h00
`define BIC_RST_BRIDGE_CTL  16'h0000
`define BIC_CTL_WMASK       16'h005F
`define BIC_PIN_MAX         8'h04
`define BIC_BIT_POISON      0
`define BIC_BIT_ERRFWD      1
`define BIC_BIT_ISA         2
`define BIC_BIT_VGA         3
`define BIC_BIT_VGA16       4
`define BIC_BIT_SECONDARY_RESET_TRIGGER      6
`define BIC_ISA_TOP         16'hFFFF
`define BIC_ISA_KB_OFF      10'h100
`define BIC_VGA_MONO_LO     16'h03B0
`define BIC_VGA_MONO_HI     16'h03BB
`define BIC_VGA_COLOR_LO    16'h03C0
`define BIC_VGA_COLOR_HI    16'h03DF
`define BIC_MSG_NONE        3'h0
`endif

//--- src/bic_sync2.v
// two-flop synchroniser for one level
`timescale 1ns/1ps
module bic_sync2 (
    // clock and reset
    input  wire mclk,
    input  wire rst_n,
    // level in and out
    input  wire d_in,
    output wire q_out
);
    reg s1_reg;
    reg s2_reg;

    // first stage feeds only the second
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
        end else begin
            s1_reg <= d_in;
            s2_reg <= s1_reg;
        end
    end

    assign q_out = s2_reg;
endmodule // bic_sync2

//--- src/bic_io_decode.v
// combinational I/O address classifier for ISA alias and VGA ranges
`timescale 1ns/1ps
`include "bic_regs.vh"
module bic_io_decode (
    // address under test
    input  wire [15:0] io_addr,
    // controls
    input  wire        isa_en,
    input  wire        vga_en,
    input  wire        vga_wide,
    // results
    output wire        isa_upstream,
    output wire        vga_hit
);
    wire [15:0] vga_a;
    wire        vga_base;

    // top 768 bytes of each 1 KB block within first 64 KB
    assign isa_upstream = isa_en && (io_addr[9:0] >= `BIC_ISA_KB_OFF); // RULE8

    // narrow decode ignores bits 15:10 so aliases match
    assign vga_a    = vga_wide ? io_addr : {6'h00, io_addr[9:0]}; // RULE11
    assign vga_base = (vga_a >= `BIC_VGA_MONO_LO && vga_a <= `BIC_VGA_MONO_HI) ||
                      (vga_a >= `BIC_VGA_COLOR_LO && vga_a <= `BIC_VGA_COLOR_HI);
    // width only matters under VGA enable
    assign vga_hit  = vga_en && vga_base; // RULE10
endmodule // bic_io_decode

//--- sim/bic_far_model.sv
// far side model: secondary link raising poisoned packets and error messages
`timescale 1ns/1ps
module bic_far_model (
    // clock and command from the bench
    input wire mclk, input wire [1:0] op, input wire [1:0] kind,
    // secondary side event lines
    output reg sec_poison, output reg sec_err_msg, output reg [1:0] sec_err_kind
);
    initial {sec_poison, sec_err_msg, sec_err_kind} = 4'h0;
    // one-cycle events; kind is scrambled while no message rides on it
    always @(posedge mclk) begin
        sec_poison   <= op == 2'h1;
        sec_err_msg  <= op == 2'h2;
        sec_err_kind <= op == 2'h2 ? kind : ~sec_err_kind;
    end
endmodule // bic_far_model

//--- sim/bic_props.sv
// assertion checker for the bridge interrupt and control bank
`timescale 1ns/1ps
module bic_props (
    // clock, reset and register port
    input wire mclk, input wire rst_n, input wire [11:0] reg_addr, input wire reg_wr,
    input wire [15:0] reg_wdata, input wire reg_rd, input wire [15:0] reg_rdata,
    // error path
    input wire cmd_err_en, input wire devctl_err_en, input wire sec_poison,
    input wire sec_err_msg, input wire [1:0] sec_err_kind, input wire pri_err_valid,
    input wire [1:0] pri_err_kind, input wire parity_err,
    // io routing and secondary reset
    input wire io_req, input wire [15:0] io_addr, input wire io_in_window,
    input wire io_fwd_down, input wire io_fwd_up, input wire sec_reset, input wire sec_reset_up
);
    reg  [7:0]  line_sh;
    reg  [15:0] ctl_sh;
    wire [9:0]  a10 = io_addr[9:0];
    // vga ranges; upper bits only count in wide mode
    wire vga = ctl_sh[3] && !(ctl_sh[4] && |io_addr[15:10]) &&
        (a10 >= 10'h3B0 && a10 <= 10'h3BB || a10 >= 10'h3C0 && a10 <= 10'h3DF);
    wire pois = sec_poison && ctl_sh[0];
    wire fwd  = sec_err_msg && ctl_sh[1] && (cmd_err_en || devctl_err_en);
    // a vga claim wins over the isa alias slot it overlaps
    wire isa  = io_req && ctl_sh[2] && io_in_window && a10 >= 10'h100 && !vga;
    wire dn   = io_req && (vga || io_in_window && !(ctl_sh[2] && a10 >= 10'h100));
    // shadow of software writes, reserved bits dropped
    always @(posedge mclk or negedge rst_n)
        if (!rst_n) begin
            line_sh <= 8'h00;
            ctl_sh  <= 16'h0000;
        end else if (reg_wr) begin
            if (reg_addr == 12'h03C) line_sh <= reg_wdata[7:0];
            if (reg_addr == 12'h03E) ctl_sh <= reg_wdata & 16'h005F;
        end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_rd_ctl; reg_rd && reg_addr == 12'h03E |=> reg_rdata == $past(ctl_sh); endproperty
    a_rd_ctl: assert property (p_rd_ctl) else $error("control readback wrong");
    property p_rd_line;
        reg_rd && reg_addr == 12'h03C |=> reg_rdata[7:0] == $past(line_sh); endproperty
    a_rd_line: assert property (p_rd_line) else $error("line readback wrong");
    property p_parity; 1 |=> parity_err == $past(pois); endproperty
    a_parity: assert property (p_parity) else $error("parity report wrong");
    property p_errfwd; 1 |=> pri_err_valid == $past(fwd); endproperty
    a_errfwd: assert property (p_errfwd) else $error("error forward wrong");
    property p_errkind; pri_err_valid |-> pri_err_kind == $past(sec_err_kind); endproperty
    a_errkind: assert property (p_errkind) else $error("error kind wrong");
    property p_isa; 1 |=> io_fwd_up == $past(isa); endproperty
    a_isa: assert property (p_isa) else $error("upstream routing wrong");
    property p_down; 1 |=> io_fwd_down == $past(dn); endproperty
    a_down: assert property (p_down) else $error("down routing wrong");
    property p_secondary_reset_trigger; 1 |=> (sec_reset || sec_reset_up) == $past(ctl_sh[6]); endproperty
    a_secondary_reset_trigger: assert property (p_secondary_reset_trigger) else $error("secondary reset wrong");
endmodule // bic_props
bind bic_top bic_props u_props (.*);

//--- sim/tb_bic_top.sv
// self-checking bench for the bridge interrupt and control bank
`timescale 1ns/1ps
`define CHK(g, e) begin exp_v = (e); n_tests++; if ((g) !== exp_v) begin err_total++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, exp_v); end end
module tb_bic_top;
    logic mclk, rst_n, reg_wr, reg_rd, cmd_en, dev_en, io_req, io_win, up_pin, rd_d = 0;
    logic [11:0] reg_addr;
    logic [15:0] reg_wdata, io_addr, exp_v, r;
    logic [1:0]  op, kind;
    logic [15:0] q[$];
    wire  [15:0] reg_rdata;
    wire  [1:0]  ekind, pkind;
    wire  [2:0]  isel;
    wire         pois, emsg, pv, pe, dn, up, sr, sru, va;
    int          err_total, n_tests, i;
    bic_far_model far_u (.mclk(mclk), .op(op), .kind(kind), .sec_poison(pois),
        .sec_err_msg(emsg), .sec_err_kind(ekind));
    bic_top dut_u (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_err_en(cmd_en),
        .devctl_err_en(dev_en), .sec_poison(pois), .sec_err_msg(emsg), .sec_err_kind(ekind),
        .pri_err_valid(pv), .pri_err_kind(pkind), .parity_err(pe), .io_req(io_req),
        .io_addr(io_addr), .io_in_window(io_win), .io_fwd_down(dn), .io_fwd_up(up),
        .port_is_upstream(up_pin), .sec_reset(sr), .sec_reset_up(sru),
        .legacy_int_sel(isel), .vga_active(va));
    // read pushes its expected data; strobe stays up until the next task
    task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
        if (!w) q.push_back(d);
        @(posedge mclk);
    endtask
    task automatic nop(input int n);
        {reg_wr, reg_rd, io_req, op} <= 0;
        repeat (n) @(posedge mclk);
    endtask
    task automatic ev(input logic [1:0] o, input logic [1:0] k, input logic y);
        {reg_wr, reg_rd, op, kind} <= {2'h0, o, k};
        if (y) q.push_back(o == 2'h1 ? 16'hA000 : {14'h3800, k});
        @(posedge mclk);
        nop(4);
    endtask
    task automatic io(input logic [15:0] a, input logic w, input logic u, input logic d);
        {reg_wr, reg_rd, io_req, io_addr, io_win} <= {3'h1, a, w};
        if (u | d) q.push_back({14'h3400, u, d});
        @(posedge mclk);
        nop(2);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // results come back in issue order, so the oldest note matches
    always @(posedge mclk) begin
        rd_d <= reg_rd;
        if (rd_d) `CHK(reg_rdata, q.pop_front())
        if (pe) `CHK(16'hA000, q.pop_front())
        if (pv) `CHK({14'h3800, pkind}, q.pop_front())
        if (up | dn) `CHK({14'h3400, up, dn}, q.pop_front())
    end
    initial begin
        mclk = 0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        err_total++;
        report_and_stop;
    end
    initial begin
        {rst_n, reg_wr, reg_rd, cmd_en, dev_en, io_req, io_win, reg_addr, reg_wdata} = 0;
        {io_addr, op, kind, up_pin} = 0;
        void'($urandom(33));
        repeat (4) @(posedge mclk);
        rst_n <= 1;
        @(posedge mclk);
        // reset values, random line, reserved and unmapped places
        bus(0, 12'h03C, 0);
        bus(0, 12'h03D, 0);
        bus(0, 12'h03E, 0);
        r = $urandom % 256;
        bus(1, 12'h03C, r);
        bus(0, 12'h03C, r);
        bus(1, 12'h03E, 16'hFFFF);
        bus(1, 12'h03F, 0);
        bus(0, 12'h03E, 16'h005F);
        bus(0, 12'h040, 0);
        $display("regs done");
        // every pin code, then one beyond the advised range
        for (i = 0; i < 6; i++) begin
            bus(1, 12'h03D, i);
            bus(0, 12'h03D, i);
            nop(2);
            `CHK(isel, i < 5 ? i : 0)
        end
        $display("pin done");
        // second reset in mid-run must clear the written line and pin registers back to zero
        rst_n <= 0;
        repeat (2) @(posedge mclk);
        rst_n <= 1;
        @(posedge mclk);
        bus(0, 12'h03C, 0);
        bus(0, 12'h03D, 0);
        nop(2);
        `CHK(isel, 0)
        // poison and error messages under every enable mix
        for (i = 0; i < 8; i++) begin
            {cmd_en, dev_en} <= {i[2], i[0] ^ i[2]};
            bus(1, 12'h03E, i[1:0]);
            ev(1, 0, i[0]);
            ev(2, i % 3, i[1] & (i[2] | i[0]));
        end
        $display("events done");
        bus(1, 12'h03E, 0);
        io(16'h1234, 1, 0, 1);
        io(16'h03C0, 0, 0, 0);
        bus(1, 12'h03E, 16'h0004);
        io(16'h0BFF, 1, 1, 0);
        io(16'h04FF, 1, 0, 1);
        bus(1, 12'h03E, 16'h0010);
        io(16'h03C0, 0, 0, 0);
        `CHK(va, 1'b0)
        bus(1, 12'h03E, 16'h0008);
        io(16'h07C0, 0, 0, 1);
        io(16'h03BB, 0, 0, 1);
        io(16'h03BC, 0, 0, 0);
        `CHK(va, 1'b1)
        bus(1, 12'h03E, 16'h0018);
        io(16'h07C0, 0, 0, 0);
        io(16'h03DF, 0, 0, 1);
        // vga range inside an isa alias slot still goes down
        bus(1, 12'h03E, 16'h000C);
        io(16'h03C0, 1, 0, 1);
        $display("io done");
        bus(1, 12'h03E, 16'h0040);
        nop(3);
        `CHK({sr, sru}, 2'h2)
        bus(1, 12'h03E, 0);
        nop(3);
        `CHK(sr, 1'b0)
        // upstream strap needs two edges through its synchroniser
        up_pin <= 1;
        nop(3);
        bus(1, 12'h03E, 16'h0040);
        nop(3);
        `CHK({sr, sru}, 2'h1)
        bus(1, 12'h03E, 0);
        nop(3);
        `CHK(sru, 1'b0)
        $display("reset done");
        nop(8);
        `CHK(q.size(), 0)
        report_and_stop;
    end
endmodule // tb_bic_top
